/* File: hw/nibble_accumulator_bcd_converter.sv */
// nibble accumulating shift register with shift-and-add-three decimal converter
`include "nacc_consts.svh"

// Summary of operation
// - the collected word lives in a 24-stage shift register with nibble parallel loads.
// - normal order puts each following channel in the next four stages, six in all.
// - normal order makes the first channel the least significant nibble.
// - reversed order puts the first channel in the last four stages, then downward.
// - a static order switch picks which group each level load addresses.
// - the controller's word reset pulse clears all twenty-four stages.
// - each strobed level value loads into the group selected for that load.
// - after the last nibble loads, the word shifts serially into the converter.
// - each shift moves the accumulator one stage and one bit into the converter.
// - the last accumulator stage, the most significant bit, enters first.
// - the converter holds each decimal digit as its own 8-4-2-1 nibble.
// - a conversion shift doubles the converter and inserts the bit at bottom.
// - before each shift, digits of five or more get three added, no carry.
// - one correct-then-shift step per bit; a full word takes 24 steps.
// - the converter has eight digits, enough for any 24-bit value.
// - msb-first converts four bits per channel; lsb-first always converts 24.
// - a single print pulse is issued when conversion finishes.
module nibble_accumulator_bcd_converter (
   input  wire logic                      clk,
   input  wire logic                      arst_n,
   input  wire logic                      order_msb_first,
   input  wire logic [2:0]                chan_count,
   input  wire logic                      word_reset,
   input  wire logic                      level_valid,
   output logic                           level_ready,
   input  wire logic [`NACC_NIB_W-1:0]    level_data,
   output logic [`NACC_BCD_W-1:0]         bcd_value,
   output logic                           print_pulse,
   output logic                           busy,
   output logic [2:0]                     groups_loaded
);
   typedef struct packed {
      nacc_pkg::conv_state_e     state;
      logic [`NACC_ACC_W-1:0]    acc;
      logic [`NACC_BCD_W-1:0]    bcd;
      logic [2:0]                grp;
      logic [4:0]                bits;
      logic                      print;
      logic                      busy;
      logic                      ord_s1;
      logic                      ord_s2;
      logic [2:0]                cnt_s1;
      logic [2:0]                cnt_s2;
      logic [4:0]                chk_shifts;
      logic [4:0]                chk_target;
      logic [`NACC_ACC_W-1:0]    chk_word;
      logic [`NACC_ACC_W-1:0]    chk_bin;
   } core_s;

   core_s                        s_r;
   core_s                        s_nxt;
   logic                         fifo_valid;
   logic                         fifo_ready;
   logic                         fifo_in_ready;
   logic [`NACC_NIB_W-1:0]       fifo_data;
   logic [2:0]                   groups_n;
   logic [2:0]                   load_pos;
   logic [4:0]                   target_bits;
   logic                         pop;
   logic [`NACC_BCD_W-1:0]       corrected;
   logic [`NACC_DIGITS-1:0]      digit_ok;
   logic [`NACC_DIGITS:0][31:0] dec_sum;

   // strobed level values queue here; back-pressure reaches the controller
   nacc_fifo #(
      .W     (`NACC_NIB_W),
      .DEPTH (`NACC_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .arst_n    (arst_n),
      .in_valid  (level_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (level_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready),
      .out_data  (fifo_data)
   );

   // clamp channel count to one..six
   always_comb begin
      if (s_r.cnt_s2 < `NACC_GRP_MIN) begin
         groups_n = `NACC_GRP_MIN;
      end else if (s_r.cnt_s2 > `NACC_GRP_MAX) begin
         groups_n = `NACC_GRP_MAX;
      end else begin
         groups_n = s_r.cnt_s2;
      end
   end

   // group addressed by the next load
   assign load_pos = s_r.ord_s2 ? (`NACC_GRP_MAX - 3'h1 - s_r.grp)
                                : s_r.grp;

   // conversion length from order and channel count
   assign target_bits = s_r.ord_s2 ? {groups_n, 2'h0} : `NACC_FULL_BITS;

   assign pop        = fifo_valid && (s_r.state == nacc_pkg::ST_LOAD)
                       && (s_r.grp < groups_n) && !word_reset;
   assign fifo_ready = pop;

   // per-digit add-three correction and range check
   genvar gi;
   assign dec_sum[`NACC_DIGITS] = 32'h00000000;
   generate
      for (gi = 0; gi < `NACC_DIGITS; gi = gi + 1) begin : g_digit
         assign corrected[gi*4 +: 4] = (s_r.bcd[gi*4 +: 4] >= `NACC_CORR_LIMIT)
                                       ? s_r.bcd[gi*4 +: 4] + `NACC_CORR_ADD
                                       : s_r.bcd[gi*4 +: 4];
         assign digit_ok[gi] = (s_r.bcd[gi*4 +: 4] <= `NACC_DIGIT_MAX);
         assign dec_sum[gi]  = (dec_sum[gi+1] * 32'h0000000A) + 32'(s_r.bcd[gi*4 +: 4]);
      end
   endgenerate

   always_comb begin
      s_nxt        = s_r;
      s_nxt.ord_s1 = order_msb_first;
      s_nxt.ord_s2 = s_r.ord_s1;
      s_nxt.cnt_s1 = chan_count;
      s_nxt.cnt_s2 = s_r.cnt_s1;
      s_nxt.print  = 1'b0;
      case (s_r.state)
         nacc_pkg::ST_LOAD: begin
            if (pop) begin
               s_nxt.acc[load_pos*4 +: 4] = fifo_data;
               s_nxt.grp                  = s_r.grp + 3'h1;
            end else if (s_r.grp >= groups_n) begin
               s_nxt.state = nacc_pkg::ST_CLEAR;
            end
         end
         nacc_pkg::ST_CLEAR: begin
            s_nxt.bcd   = `NACC_BCD_RST;
            s_nxt.bits  = target_bits;
            s_nxt.state = nacc_pkg::ST_ADD;
         end
         nacc_pkg::ST_ADD: begin
            s_nxt.bcd   = corrected;
            s_nxt.state = nacc_pkg::ST_SHIFT;
         end
         nacc_pkg::ST_SHIFT: begin
            s_nxt.acc  = {s_r.acc[`NACC_ACC_W-2:0], 1'b0};
            s_nxt.bcd  = {s_r.bcd[`NACC_BCD_W-2:0], s_r.acc[`NACC_ACC_W-1]};
            s_nxt.bits = s_r.bits - 5'h01;
            if (s_r.bits == 5'h01) begin
               s_nxt.state = nacc_pkg::ST_DONE;
               s_nxt.print = 1'b1;
            end else begin
               s_nxt.state = nacc_pkg::ST_ADD;
            end
         end
         nacc_pkg::ST_DONE: begin
            s_nxt.state = nacc_pkg::ST_DONE;
         end
         default: begin
            s_nxt.state = nacc_pkg::ST_LOAD;
         end
      endcase
      if (word_reset) begin
         s_nxt.state = nacc_pkg::ST_LOAD;
         s_nxt.acc   = `NACC_ACC_RST;
         s_nxt.grp   = 3'h0;
         s_nxt.bits  = 5'h00;
         s_nxt.print = 1'b0;
      end
      s_nxt.busy  = (s_nxt.state != nacc_pkg::ST_LOAD);
      // shadow of the converted bits for checking
      if (s_r.state == nacc_pkg::ST_CLEAR) begin
         s_nxt.chk_shifts = 5'h00;
         s_nxt.chk_target = s_r.ord_s2 ? 5'(groups_n) * 5'(`NACC_NIB_W) : `NACC_FULL_BITS;
         s_nxt.chk_word   = s_r.acc;
         s_nxt.chk_bin    = `NACC_ACC_RST;
      end else if (s_r.state == nacc_pkg::ST_SHIFT) begin
         s_nxt.chk_shifts = s_r.chk_shifts + 5'h01;
         s_nxt.chk_bin    = {s_r.chk_bin[`NACC_ACC_W-2:0], s_r.acc[`NACC_ACC_W-1]};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r       <= '0;
         s_r.state <= nacc_pkg::ST_LOAD;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign level_ready   = fifo_in_ready;
   assign bcd_value     = s_r.bcd;
   assign print_pulse   = s_r.print;
   assign busy          = s_r.busy;
   assign groups_loaded = s_r.grp;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   a_reset_clears_acc: assert property (
      word_reset |=> (s_r.acc == `NACC_ACC_RST) && (s_r.grp == 3'h0)
   ) else $error("accumulator not cleared by word reset");

   a_lsb_first_low: assert property (
      (pop && !s_r.ord_s2 && s_r.grp == 3'h0) |=> s_r.acc[3:0] == $past(fifo_data)
   ) else $error("first lsb-order nibble not in lowest group");

   a_msb_first_high: assert property (
      (pop && s_r.ord_s2 && s_r.grp == 3'h0) |=> s_r.acc[23:20] == $past(fifo_data)
   ) else $error("first msb-order nibble not in highest group");

   a_load_group: assert property (
      (pop && !s_r.ord_s2 && s_r.grp == 3'h1) |=> s_r.acc[7:4] == $past(fifo_data)
   ) else $error("second lsb-order nibble misplaced");

   a_start_convert: assert property (
      (s_r.state == nacc_pkg::ST_LOAD && s_r.grp >= groups_n && !word_reset && !pop)
      |=> s_r.state == nacc_pkg::ST_CLEAR ##1 s_r.bcd == `NACC_BCD_RST
   ) else $error("conversion did not start with a cleared converter");

   a_shift_step: assert property (
      (s_r.state == nacc_pkg::ST_SHIFT && !word_reset)
      |=> (s_r.acc == {$past(s_r.acc[22:0]), 1'b0})
          && (s_r.bcd[0] == $past(s_r.acc[23]))
          && (s_r.bcd[31:1] == $past(s_r.bcd[30:0]))
   ) else $error("shift step moved the wrong bits");

   a_add_then_shift: assert property (
      (s_r.state == nacc_pkg::ST_ADD && !word_reset)
      |=> (s_r.bcd == $past(corrected)) && (s_r.state == nacc_pkg::ST_SHIFT)
   ) else $error("correction not followed by a shift");

   a_digits_valid: assert property (
      print_pulse |-> (&digit_ok)
   ) else $error("converted digit out of decimal range");

   a_conv_length: assert property (
      print_pulse |-> (s_r.chk_shifts == s_r.chk_target)
   ) else $error("conversion length differs from expected");

   a_print_single: assert property (
      print_pulse |=> !print_pulse && (s_r.state == nacc_pkg::ST_DONE || $past(word_reset))
   ) else $error("print pulse longer than one cycle");

   a_word_value: assert property (
      print_pulse
      |-> (dec_sum[0] == 32'(s_r.chk_bin))
   ) else $error("decimal result differs from converted bits");

   a_msb_enters: assert property (
      print_pulse
      |-> (s_r.chk_bin == (s_r.chk_word >> (`NACC_FULL_BITS - s_r.chk_target)))
   ) else $error("converted bits not taken from the top stage first");

   a_msb_second: assert property (
      (pop && s_r.ord_s2 && s_r.grp == 3'h1)
      |=> s_r.acc[19:16] == $past(fifo_data)
   ) else $error("second msb-order nibble misplaced");

   a_msb_third: assert property (
      (pop && s_r.ord_s2 && s_r.grp == 3'h2)
      |=> s_r.acc[15:12] == $past(fifo_data)
   ) else $error("third msb-order nibble misplaced");

   a_msb_last: assert property (
      (pop && s_r.ord_s2 && s_r.grp == 3'h5)
      |=> s_r.acc[3:0] == $past(fifo_data)
   ) else $error("sixth msb-order nibble not in lowest group");

   a_lsb_last: assert property (
      (pop && !s_r.ord_s2 && s_r.grp == 3'h5)
      |=> s_r.acc[23:20] == $past(fifo_data)
   ) else $error("sixth lsb-order nibble not in highest group");

   a_load_keeps: assert property (
      (pop && !s_r.ord_s2 && s_r.grp == 3'h1)
      |=> s_r.acc[3:0] == $past(s_r.acc[3:0])
   ) else $error("nibble load disturbed another group");

   a_load_count: assert property (
      pop
      |=> groups_loaded == $past(groups_loaded) + 3'h1
   ) else $error("loaded group count did not advance");

   a_group_limit: assert property (
      pop
      |-> (s_r.grp < `NACC_GRP_MAX)
   ) else $error("load beyond the sixth group");

   a_reset_stops: assert property (
      word_reset
      |=> !busy && !print_pulse && (s_r.state == nacc_pkg::ST_LOAD)
   ) else $error("word reset did not stop the conversion");

   a_no_take_busy: assert property (
      busy
      |-> !fifo_ready
   ) else $error("level value taken during conversion");

   a_acc_held: assert property (
      (s_r.state == nacc_pkg::ST_ADD && !word_reset)
      |=> $stable(s_r.acc)
   ) else $error("accumulator moved during correction");

   a_clear_start: assert property (
      (s_r.state == nacc_pkg::ST_CLEAR && !word_reset)
      |=> (s_r.state == nacc_pkg::ST_ADD) && (s_r.bcd == `NACC_BCD_RST) && (s_r.bits == s_r.chk_target)
   ) else $error("conversion start state wrong");

   a_units_fix: assert property (
      (s_r.state == nacc_pkg::ST_ADD && !word_reset && s_r.bcd[3:0] >= 4'h5)
      |=> s_r.bcd[3:0] == $past(s_r.bcd[3:0]) + 4'h3
   ) else $error("units digit not corrected");

   a_units_keep: assert property (
      (s_r.state == nacc_pkg::ST_ADD && !word_reset && s_r.bcd[3:0] < 4'h5)
      |=> $stable(s_r.bcd[3:0])
   ) else $error("units digit corrected below five");

   a_tens_keep: assert property (
      (s_r.state == nacc_pkg::ST_ADD && !word_reset && s_r.bcd[7:4] < 4'h5)
      |=> $stable(s_r.bcd[7:4])
   ) else $error("tens digit corrected below five");

   a_high_fix: assert property (
      (s_r.state == nacc_pkg::ST_ADD && !word_reset && s_r.bcd[27:24] >= 4'h5)
      |=> s_r.bcd[27:24] == $past(s_r.bcd[27:24]) + 4'h3
   ) else $error("seventh digit not corrected");

   a_step_count: assert property (
      (s_r.state == nacc_pkg::ST_SHIFT && !word_reset && s_r.bits != 5'h01)
      |=> (s_r.state == nacc_pkg::ST_ADD) && (s_r.bits == $past(s_r.bits) - 5'h01) && !print_pulse
   ) else $error("conversion step count wrong");

   a_last_print: assert property (
      (s_r.state == nacc_pkg::ST_SHIFT && !word_reset && s_r.bits == 5'h01)
      |=> print_pulse && (s_r.state == nacc_pkg::ST_DONE)
   ) else $error("no print pulse after the last shift");

   a_done_holds: assert property (
      (s_r.state == nacc_pkg::ST_DONE && !word_reset)
      |=> (s_r.state == nacc_pkg::ST_DONE) && $stable(bcd_value) && !print_pulse
   ) else $error("finished result not held");

   a_bcd_idle: assert property (
      (s_r.state == nacc_pkg::ST_LOAD)
      |=> $stable(s_r.bcd)
   ) else $error("converter changed while loading");
endmodule

/* File: common/nacc_consts.svh */
// constants for the nibble accumulator and decimal converter
`ifndef NACC_CONSTS_SVH
`define NACC_CONSTS_SVH
`define NACC_NIB_W        4
`define NACC_ACC_W        24
`define NACC_GROUPS       6
`define NACC_DIGITS       8
`define NACC_BCD_W        32
`define NACC_FIFO_DEPTH   4
`define NACC_ACC_RST      24'h000000
`define NACC_BCD_RST      32'h00000000
`define NACC_CORR_LIMIT   4'h5
`define NACC_CORR_ADD     4'h3
`define NACC_DIGIT_MAX    4'h9
`define NACC_FULL_BITS    5'h18
`define NACC_GRP_MIN      3'h1
`define NACC_GRP_MAX      3'h6
`endif

/* File: common/nacc_pkg.sv */
// types shared by the accumulator and converter
package nacc_pkg;
   typedef enum logic [4:0] {
      ST_LOAD  = 5'h01,
      ST_CLEAR = 5'h02,
      ST_ADD   = 5'h04,
      ST_SHIFT = 5'h08,
      ST_DONE  = 5'h10
   } conv_state_e;
endpackage

/* File: hw/nacc_fifo.sv */
// small valid/ready fifo
module nacc_fifo #(
   parameter int W     = 4,
   parameter int DEPTH = 4
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0]           wr;
      logic [PW-1:0]           rd;
      logic [CW-1:0]           cnt;
      logic                    rdy;
   } fifo_s;

   fifo_s s_r;
   fifo_s s_nxt;
   logic  push;
   logic  pop;

   assign push      = in_valid && s_r.rdy;
   assign pop       = out_ready && (s_r.cnt != '0);
   assign in_ready  = s_r.rdy;
   assign out_valid = (s_r.cnt != '0);
   assign out_data  = s_r.mem[s_r.rd];

   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wr] = in_data;
         s_nxt.wr = (s_r.wr == PW'(DEPTH - 1)) ? '0 : s_r.wr + 1'b1;
      end
      if (pop) begin
         s_nxt.rd = (s_r.rd == PW'(DEPTH - 1)) ? '0 : s_r.rd + 1'b1;
      end
      if (push && !pop) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (pop && !push) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
      s_nxt.rdy = (s_nxt.cnt != CW'(DEPTH));
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r     <= '0;
         s_r.rdy <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

/* File: verification/level_source.sv */
// partner model: level selector and time control pulses
module level_source (
   input  wire logic  clk,
   input  wire logic  level_ready,
   output logic       word_reset,
   output logic       level_valid,
   output logic [3:0] level_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      word_reset  = 1'b0;
      level_valid = 1'b0;
      level_data  = 4'hA;
   end
   // word reset pulse, called at a falling edge
   task automatic pulse_reset();
      word_reset = 1'b1;
      @(negedge clk);
      word_reset = 1'b0;
   endtask
   // strobe one level value, held until taken
   task automatic send(input logic [3:0] v, input int gap, output bit ok);
      int k;
      if (gap > 0) begin
         level_valid = 1'b0;
         level_data  = ~level_data;
         repeat (gap) @(negedge clk);
      end
      level_valid = 1'b1;
      level_data  = v;
      k = 0;
      while (level_ready !== 1'b1 && k < 100) begin
         @(negedge clk);
         k++;
      end
      ok = (level_ready === 1'b1);
      @(negedge clk);
   endtask
   // released line shows the inverse of the last value
   task automatic idle();
      level_valid = 1'b0;
      level_data  = ~level_data;
   endtask
endmodule

/* File: verification/tb.sv */
// bench for the nibble accumulator and decimal converter
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk;
   logic        arst_n;
   logic        order_msb_first;
   logic [2:0]  chan_count;
   logic        word_reset;
   logic        level_valid;
   logic        level_ready;
   logic [3:0]  level_data;
   logic [31:0] bcd_value;
   logic        print_pulse;
   logic        busy;
   logic [2:0]  groups_loaded;
   int          errors;
   int          checks_done;
   int          seed;
   int          n;
   logic [23:0] w;
   always #5 clk = ~clk;
   nibble_accumulator_bcd_converter uut (
      .clk(clk), .arst_n(arst_n), .order_msb_first(order_msb_first),
      .chan_count(chan_count), .word_reset(word_reset), .level_valid(level_valid),
      .level_ready(level_ready), .level_data(level_data), .bcd_value(bcd_value),
      .print_pulse(print_pulse), .busy(busy), .groups_loaded(groups_loaded));
   level_source src (
      .clk(clk), .level_ready(level_ready), .word_reset(word_reset),
      .level_valid(level_valid), .level_data(level_data));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wait_high(input bit on_print, input int lim);
      n = 0;
      while ((on_print ? print_pulse : busy) !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      if ((on_print ? print_pulse : busy) !== 1'b1) begin
         errors++;
         $display("FAIL %0t wait timed out", $time);
         wrap_up();
      end
   endtask
   // decimal digits of the assembled word
   function automatic logic [31:0] exp_bcd(input logic [23:0] nibs, input int cnt, input bit msb);
      logic [23:0] v;
      logic [31:0] r;
      v = 24'h000000;
      for (int k = 0; k < cnt; k++) begin
         if (msb) v[20-4*k +: 4] = nibs[4*k +: 4];
         else v[4*k +: 4] = nibs[4*k +: 4];
      end
      if (msb) v = v >> (24 - 4 * cnt);
      for (int d = 0; d < 8; d++) begin
         r[4*d +: 4] = 4'(v % 10);
         v = v / 10;
      end
      return r;
   endfunction
   task automatic load_word(input logic [23:0] nibs, input int cnt, input bit slow);
      bit ok;
      for (int k = 0; k < cnt; k++) begin
         src.send(nibs[4*k +: 4], slow ? 2 : 0, ok);
         if (!ok) begin
            errors++;
            $display("FAIL %0t level value not taken", $time);
            wrap_up();
         end
      end
      src.idle();
   endtask
   task automatic finish_word(input logic [23:0] nibs, input int cnt, input bit msb);
      wait_high(1'b0, 60);
      check(32'(groups_loaded), cnt, "groups loaded");
      wait_high(1'b1, 60);
      check(n, msb ? 8 * cnt + 1 : 49, "conversion cycles");
      check(bcd_value, exp_bcd(nibs, cnt, msb), "decimal result");
      @(negedge clk);
      check(32'(print_pulse), 0, "print width");
   endtask
   task automatic run_word(input logic [23:0] nibs, input int cnt, input bit msb, input bit slow);
      order_msb_first = msb;
      chan_count = 3'(cnt);
      repeat (3) @(negedge clk);
      src.pulse_reset();
      load_word(nibs, cnt, slow);
      finish_word(nibs, cnt, msb);
   endtask
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      order_msb_first = 1'b0;
      chan_count = 3'h6;
      errors = 0;
      checks_done = 0;
      seed = 32'h3801c5b7;
      n = 0;
      repeat (5) @(negedge clk);
      check(bcd_value, 0, "reset result");
      check(32'({busy, print_pulse, level_ready, groups_loaded}), 32'h8, "reset flags");
      arst_n = 1'b1;
      run_word(24'hFFFFFF, 6, 1'b0, 1'b0);
      run_word(24'h999999, 6, 1'b1, 1'b0);
      for (int m = 0; m < 12; m++) begin
         w = 24'($random(seed));
         run_word(w, m % 6 + 1, m >= 6, w[0]);
      end
      // abort in mid conversion
      order_msb_first = 1'b0;
      chan_count = 3'h6;
      repeat (3) @(negedge clk);
      src.pulse_reset();
      load_word(24'h654321, 6, 1'b0);
      wait_high(1'b0, 60);
      repeat (6) @(negedge clk);
      src.pulse_reset();
      check(32'(busy), 0, "abort clears busy");
      check(32'(groups_loaded), 0, "abort clears groups");
      repeat (60) begin
         @(negedge clk);
         check(32'(print_pulse), 0, "no print after abort");
      end
      // fill the fifo while the finished word waits
      w = 24'($random(seed));
      run_word(w, 4, 1'b0, 1'b0);
      load_word(24'h008421, 4, 1'b0);
      @(negedge clk);
      check(32'(level_ready), 0, "fifo full");
      check(32'(groups_loaded), 4, "queued values held");
      src.pulse_reset();
      finish_word(24'h008421, 4, 1'b0);
      // switch settings outside one..six are clamped
      w = 24'($random(seed));
      for (int c = 0; c < 2; c++) begin
         order_msb_first = 1'b1;
         chan_count = (c != 0) ? 3'h7 : 3'h0;
         repeat (3) @(negedge clk);
         src.pulse_reset();
         load_word(w, (c != 0) ? 6 : 1, 1'b0);
         finish_word(w, (c != 0) ? 6 : 1, 1'b1);
      end
      wrap_up();
   end
endmodule
